// [rtl/pccp_pkg.sv]
package pccp_pkg;

  // register offsets on the register port
  localparam logic [7:0] UNLOCK_KEY_OFS = 8'hc1;
  localparam logic [7:0] POWER_CONTROL_OFS = 8'hc5;
  localparam logic [7:0] MEASUREMENT_START_OFS = 8'hd8;
  localparam logic [7:0] IRQ_STATUS_OFS = 8'he0;
  localparam logic [7:0] IRQ_MASK_OFS = 8'he1;
  localparam logic [7:0] PERIPHERAL_CONFIGURATION_OFS = 8'hf4;

  // key values
  localparam logic [7:0] POWER_KEY = 8'ha7;
  localparam logic [7:0] TIMEKEEPING_KEY = 8'hea;

  // power_control fields
  localparam int METER_OFF_BIT = 6;
  localparam int CORE_SHUTDOWN_BIT = 4;
  localparam int CORE_DIV_LSB = 0;
  localparam int CORE_DIV_W = 3;

  // peripheral_configuration fields
  localparam int RX_WAKE_FLAG_BIT = 7;
  localparam int SUPPLY_SOURCE_BIT = 6;
  localparam int SUPPLY_GOOD_BIT = 5;
  localparam int LOCK_FAULT_BIT = 4;
  localparam int EXT_REF_BIT = 2;
  localparam int RX_FUNC_LSB = 0;

  // measurement_start fields
  localparam int LOCK_FAULT_CLEAR_BIT = 7;

  // interrupt status and mask bits
  localparam int IRQ_LOCK_FAULT_BIT = 0;
  localparam int IRQ_RX_WAKE_BIT = 1;

  // receive pin function encodings
  localparam logic [1:0] RX_FUNC_GPIO = 2'h0;
  localparam logic [1:0] RX_FUNC_SERIAL = 2'h1;
  localparam logic [1:0] RX_FUNC_SERIAL_WAKE = 2'h3;

  // reset values
  localparam logic [2:0] CORE_DIV_RST = 3'h2;
  localparam logic SUPPLY_SOURCE_RST = 1'b1;
  localparam logic [1:0] RX_FUNC_RST = 2'h0;
  localparam logic [1:0] IRQ_MASK_RST = 2'h0;

  // timing: pll clock derived from the system clock by a phase accumulator
  localparam int CLK_FREQ_KHZ = 100000;
  localparam int CRYSTAL_FREQ_HZ = 32768;
  localparam int PLL_MULTIPLIER = 125;
  localparam int PLL_FREQ_KHZ = CRYSTAL_FREQ_HZ * PLL_MULTIPLIER / 1000;
  localparam logic [16:0] PLL_ACC_STEP = 17'(PLL_FREQ_KHZ);
  localparam logic [16:0] PLL_ACC_MOD = 17'(CLK_FREQ_KHZ);
  localparam logic [2:0] METER_DIV = 3'h5;
  localparam int CORE_CNT_W = 7;

  typedef struct packed {
    logic [16:0] acc;
    logic pll_tick;
    logic [2:0] meter_cnt;
    logic meter_tick;
    logic meter_off;
    logic core_off;
    logic [2:0] div;
    logic arm_power;
    logic arm_time;
    logic rx_flag;
    logic supply_main;
    logic vdd_ok;
    logic lock_fault;
    logic locked_prev;
    logic core_reset;
    logic ext_ref;
    logic [1:0] rx_func;
    logic [1:0] irq_status;
    logic [1:0] irq_mask;
    logic irq;
    logic [7:0] rd_data;
  } pccp_state_s;

  localparam pccp_state_s PCCP_STATE_RST = '{
    div: CORE_DIV_RST,
    supply_main: SUPPLY_SOURCE_RST,
    rx_func: RX_FUNC_RST,
    irq_mask: IRQ_MASK_RST,
    default: '0
  };

  typedef struct packed {
    logic [CORE_CNT_W-1:0] cnt;
    logic tick;
  } pccp_div_s;

endpackage

// [rtl/pccp_core_div.sv]
`timescale 1ns/100ps
// counts pll ticks and passes one in 2**divider on as a core tick
module pccp_core_div (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic pll_tick,
  input wire logic [2:0] divider,
  output logic core_tick
);

  pccp_pkg::pccp_div_s s_q;
  pccp_pkg::pccp_div_s s_d;
  logic [pccp_pkg::CORE_CNT_W-1:0] phase_mask;

  always_comb begin
    s_d = s_q;
    phase_mask = (pccp_pkg::CORE_CNT_W)'((8'h1 << divider) - 8'h1);
    s_d.tick = 1'b0;
    if (pll_tick) begin
      // a divider change takes effect at the next aligned phase, no runt tick
      s_d.tick = ((s_q.cnt & phase_mask) == '0);
      s_d.cnt = s_q.cnt + 1'b1;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign core_tick = s_q.tick;

endmodule

// [rtl/pccp_top.sv]
// The address-and-strobe port was decided locally.
`timescale 1ns/100ps
module pccp_top (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [7:0] addr,
  input wire logic [7:0] wr_data,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [7:0] rd_data,
  input wire logic pll_locked,
  input wire logic power_save_mode_one_active,
  input wire logic power_save_mode_two_active,
  input wire logic rx_wake_edge,
  input wire logic supply_is_main,
  input wire logic supply_good,
  output logic pll_tick,
  output logic core_tick,
  output logic meter_tick,
  output logic [2:0] core_clock_divider,
  output logic meter_off,
  output logic core_shutdown,
  output logic core_reset,
  output logic timekeeping_unlock,
  output logic external_reference_enable,
  output logic rx_serial_select,
  output logic rx_wake_enable,
  output logic irq
);

  pccp_pkg::pccp_state_s s_q;
  pccp_pkg::pccp_state_s s_d;

  logic wr_key;
  logic wr_power;
  logic wr_start;
  logic wr_peripheral_configuration;
  logic wr_status;
  logic wr_mask;
  logic lock_lost;
  logic rx_wake_event;
  logic [7:0] power_rd;
  logic [7:0] peripheral_configuration_rd;
  logic [1:0] irq_events;
  logic [17:0] acc_sum;

  always_comb begin
    wr_key = 1'b0;
    wr_power = 1'b0;
    wr_start = 1'b0;
    wr_peripheral_configuration = 1'b0;
    wr_status = 1'b0;
    wr_mask = 1'b0;
    if (wr_en && addr == pccp_pkg::UNLOCK_KEY_OFS) begin
      wr_key = 1'b1;
    end else if (wr_en && addr == pccp_pkg::POWER_CONTROL_OFS) begin
      wr_power = 1'b1;
    end else if (wr_en && addr == pccp_pkg::MEASUREMENT_START_OFS) begin
      wr_start = 1'b1;
    end else if (wr_en && addr == pccp_pkg::PERIPHERAL_CONFIGURATION_OFS) begin
      wr_peripheral_configuration = 1'b1;
    end else if (wr_en && addr == pccp_pkg::IRQ_STATUS_OFS) begin
      wr_status = 1'b1;
    end else if (wr_en && addr == pccp_pkg::IRQ_MASK_OFS) begin
      wr_mask = 1'b1;
    end
  end

  // reserved bits read as zero
  always_comb begin
    power_rd = '0;
    power_rd[pccp_pkg::METER_OFF_BIT] = s_q.meter_off;
    power_rd[pccp_pkg::CORE_SHUTDOWN_BIT] = s_q.core_off;
    power_rd[pccp_pkg::CORE_DIV_LSB +: pccp_pkg::CORE_DIV_W] = s_q.div;
    peripheral_configuration_rd = '0;
    peripheral_configuration_rd[pccp_pkg::RX_WAKE_FLAG_BIT] = s_q.rx_flag;
    peripheral_configuration_rd[pccp_pkg::SUPPLY_SOURCE_BIT] = s_q.supply_main;
    peripheral_configuration_rd[pccp_pkg::SUPPLY_GOOD_BIT] = s_q.vdd_ok;
    peripheral_configuration_rd[pccp_pkg::LOCK_FAULT_BIT] = s_q.lock_fault;
    peripheral_configuration_rd[pccp_pkg::EXT_REF_BIT] = s_q.ext_ref;
    peripheral_configuration_rd[pccp_pkg::RX_FUNC_LSB +: 2] = s_q.rx_func;
  end

  assign lock_lost = s_q.locked_prev && !pll_locked;
  assign rx_wake_event = rx_wake_edge && power_save_mode_two_active &&
                         s_q.rx_func == pccp_pkg::RX_FUNC_SERIAL_WAKE;
  assign acc_sum = {1'b0, s_q.acc} + {1'b0, pccp_pkg::PLL_ACC_STEP};

  always_comb begin
    s_d = s_q;
    irq_events = '0;

    // fractional accumulator keeps the long-term pll rate exact
    s_d.pll_tick = 1'b0;
    if (acc_sum >= {1'b0, pccp_pkg::PLL_ACC_MOD}) begin
      s_d.acc = 17'(acc_sum - {1'b0, pccp_pkg::PLL_ACC_MOD});
      s_d.pll_tick = 1'b1;
    end else begin
      s_d.acc = 17'(acc_sum);
    end

    // metering divider never looks at the core divider
    s_d.meter_tick = 1'b0;
    if (s_q.pll_tick) begin
      if (s_q.meter_cnt == pccp_pkg::METER_DIV - 3'h1) begin
        s_d.meter_cnt = '0;
        s_d.meter_tick = 1'b1;
      end else begin
        s_d.meter_cnt = s_q.meter_cnt + 3'h1;
      end
    end

    // key handling: any write other than the key disarms both keys
    if (wr_en) begin
      s_d.arm_power = 1'b0;
      s_d.arm_time = 1'b0;
    end
    if (wr_key) begin
      s_d.arm_power = (wr_data == pccp_pkg::POWER_KEY);
      s_d.arm_time = (wr_data == pccp_pkg::TIMEKEEPING_KEY);
    end
    if (wr_power && s_q.arm_power) begin
      s_d.meter_off = wr_data[pccp_pkg::METER_OFF_BIT];
      s_d.core_off = wr_data[pccp_pkg::CORE_SHUTDOWN_BIT];
      s_d.div = wr_data[pccp_pkg::CORE_DIV_LSB +: pccp_pkg::CORE_DIV_W];
    end

    // supply status follows its inputs one cycle late
    s_d.supply_main = supply_is_main;
    s_d.vdd_ok = supply_good;

    if (wr_peripheral_configuration) begin
      s_d.ext_ref = wr_data[pccp_pkg::EXT_REF_BIT];
      s_d.rx_func = wr_data[pccp_pkg::RX_FUNC_LSB +: 2];
      if (wr_data[pccp_pkg::RX_WAKE_FLAG_BIT]) begin
        s_d.rx_flag = 1'b0;
      end
    end
    // a wake edge in the clearing cycle is kept
    if (rx_wake_event) begin
      s_d.rx_flag = 1'b1;
      irq_events[pccp_pkg::IRQ_RX_WAKE_BIT] = 1'b1;
    end

    // lock fault: acknowledge first, so a coincident loss still sets it
    s_d.locked_prev = pll_locked;
    s_d.core_reset = lock_lost;
    if (wr_start && wr_data[pccp_pkg::LOCK_FAULT_CLEAR_BIT]) begin
      s_d.lock_fault = 1'b0;
    end
    if (lock_lost) begin
      s_d.lock_fault = 1'b1;
      irq_events[pccp_pkg::IRQ_LOCK_FAULT_BIT] = 1'b1;
    end

    // interrupt status: write one to clear, set wins
    if (wr_status) begin
      s_d.irq_status = s_q.irq_status & ~wr_data[1:0];
    end
    s_d.irq_status = s_d.irq_status | irq_events;
    if (wr_mask) begin
      s_d.irq_mask = wr_data[1:0];
    end
    s_d.irq = |(s_d.irq_status & s_d.irq_mask);

    s_d.rd_data = '0;
    if (rd_en) begin
      if (addr == pccp_pkg::POWER_CONTROL_OFS) begin
        s_d.rd_data = power_rd;
      end else if (addr == pccp_pkg::PERIPHERAL_CONFIGURATION_OFS) begin
        s_d.rd_data = peripheral_configuration_rd;
      end else if (addr == pccp_pkg::IRQ_STATUS_OFS) begin
        s_d.rd_data = {6'h00, s_q.irq_status};
      end else if (addr == pccp_pkg::IRQ_MASK_OFS) begin
        s_d.rd_data = {6'h00, s_q.irq_mask};
      end else begin
        // key, measurement_start and unmapped addresses read zero
        s_d.rd_data = 8'h00;
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s_q <= pccp_pkg::PCCP_STATE_RST;
    end else begin
      s_q <= s_d;
    end
  end

  pccp_core_div u_core_div (
    .clk(clk),
    .arst_n(arst_n),
    .pll_tick(s_q.pll_tick),
    .divider(s_q.div),
    .core_tick(core_tick)
  );

  assign rd_data = s_q.rd_data;
  assign pll_tick = s_q.pll_tick;
  assign meter_tick = s_q.meter_tick;
  assign core_clock_divider = s_q.div;
  assign meter_off = s_q.meter_off;
  // shutdown only bites in mode one
  assign core_shutdown = s_q.core_off && power_save_mode_one_active;
  assign core_reset = s_q.core_reset;
  assign timekeeping_unlock = s_q.arm_time;
  assign external_reference_enable = s_q.ext_ref;
  // the reserved code 10 falls through to gpio
  assign rx_serial_select = (s_q.rx_func == pccp_pkg::RX_FUNC_SERIAL) ||
                            (s_q.rx_func == pccp_pkg::RX_FUNC_SERIAL_WAKE);
  assign rx_wake_enable = (s_q.rx_func == pccp_pkg::RX_FUNC_SERIAL_WAKE);
  assign irq = s_q.irq;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);

  property p_pll_rate;
    pll_tick |=> !pll_tick [*8] ##1 !pll_tick [*8] ##1 !pll_tick [*7] ##[1:2] pll_tick;
  endproperty
  a_pll_rate: assert property (p_pll_rate) else $error("pll tick spacing wrong");

  property p_core_tick_phase;
    core_tick |-> $past(pll_tick);
  endproperty
  a_core_tick_phase: assert property (p_core_tick_phase)
    else $error("core tick not on pll");

  property p_core_tick_full;
    (pll_tick && core_clock_divider == 3'h0 && $stable(core_clock_divider)) |=> core_tick;
  endproperty
  a_core_tick_full: assert property (p_core_tick_full)
    else $error("undivided core tick missing");

  property p_meter_gap;
    meter_tick |=> !meter_tick [*8];
  endproperty
  a_meter_gap: assert property (p_meter_gap) else $error("meter tick too fast");

  property p_div_keyed;
    !$stable(core_clock_divider) |-> $past(wr_power) && $past(s_q.arm_power);
  endproperty
  a_div_keyed: assert property (p_div_keyed) else $error("divider changed without key");

  property p_key_one_shot;
    (wr_power && s_q.arm_power) |=> !s_q.arm_power;
  endproperty
  a_key_one_shot: assert property (p_key_one_shot) else $error("key unlocked twice");

  property p_time_key;
    (wr_key && wr_data == pccp_pkg::TIMEKEEPING_KEY) |=> timekeeping_unlock;
  endproperty
  a_time_key: assert property (p_time_key) else $error("timekeeping key ignored");

  property p_lock_loss;
    $fell(pll_locked) |=> core_reset && s_q.lock_fault;
  endproperty
  a_lock_loss: assert property (p_lock_loss) else $error("lock loss not handled");

  property p_fault_ack;
    (wr_start && wr_data[7] && !lock_lost) |=> !s_q.lock_fault;
  endproperty
  a_fault_ack: assert property (p_fault_ack) else $error("fault not acknowledged");

  property p_rx_flag_cause;
    $rose(s_q.rx_flag) |-> $past(rx_wake_edge) && $past(power_save_mode_two_active);
  endproperty
  a_rx_flag_cause: assert property (p_rx_flag_cause)
    else $error("wake flag without edge");

  property p_shutdown_mode;
    core_shutdown |-> power_save_mode_one_active;
  endproperty
  a_shutdown_mode: assert property (p_shutdown_mode)
    else $error("shutdown outside mode one");

  property p_reserved_zero;
    (rd_en && addr == pccp_pkg::PERIPHERAL_CONFIGURATION_OFS) |=> rd_data[3] == 1'b0;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero)
    else $error("reserved bit not zero");

  property p_power_reserved;
    (rd_en && addr == pccp_pkg::POWER_CONTROL_OFS) |=> (rd_data & 8'ha8) == 8'h00;
  endproperty
  a_power_reserved: assert property (p_power_reserved)
    else $error("power reserved bit set");

  property p_div_follow;
    (wr_power && s_q.arm_power) |=>
      core_clock_divider == $past(wr_data[pccp_pkg::CORE_DIV_LSB +: pccp_pkg::CORE_DIV_W]);
  endproperty
  a_div_follow: assert property (p_div_follow) else $error("keyed divider write lost");

  property p_unkeyed_ignored;
    (wr_power && !s_q.arm_power) |=> $stable(core_clock_divider) && $stable(meter_off);
  endproperty
  a_unkeyed_ignored: assert property (p_unkeyed_ignored)
    else $error("unkeyed write took effect");

  property p_meter_phase;
    meter_tick |-> $past(pll_tick);
  endproperty
  a_meter_phase: assert property (p_meter_phase) else $error("meter tick off pll");

  property p_reset_pulse;
    core_reset |=> !core_reset;
  endproperty
  a_reset_pulse: assert property (p_reset_pulse) else $error("core reset too long");

  property p_fault_sticky;
    (s_q.lock_fault && !wr_start) |=> s_q.lock_fault;
  endproperty
  a_fault_sticky: assert property (p_fault_sticky) else $error("fault flag lost");

  property p_supply_follow;
    supply_is_main |=> s_q.supply_main;
  endproperty
  a_supply_follow: assert property (p_supply_follow) else $error("supply source lost");

  property p_vdd_follow;
    !supply_good |=> !s_q.vdd_ok;
  endproperty
  a_vdd_follow: assert property (p_vdd_follow) else $error("supply good stuck");

  c_keyed_write: cover property (wr_key ##[1:8] (wr_power && s_q.arm_power));
  c_lock_loss: cover property ($fell(pll_locked) ##[1:60] wr_start);
  c_rx_wake: cover property (rx_wake_event ##1 s_q.rx_flag);
  c_slow_core: cover property (core_tick && core_clock_divider == 3'h7);

endmodule

// [tb/pccp_xtal_model.sv]
`timescale 1ns/100ps
// crystal and pll lock source: lock comes up a while after reset and
// drops only on request, so every lock loss seen by the block is deliberate
module pccp_xtal_model #(
  parameter int LOCK_CYCLES = 16
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic lose_lock,
  output logic pll_locked
);
  int cnt;
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt <= 0;
      pll_locked <= 1'b0;
    end else if (lose_lock) begin
      cnt <= 0;
      pll_locked <= 1'b0;
    end else if (cnt < LOCK_CYCLES) begin
      cnt <= cnt + 1;
    end else begin
      pll_locked <= 1'b1;
    end
  end
endmodule

// [tb/testbench.sv]
`timescale 1ns/100ps
module testbench;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wr_data = 8'h00;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic power_save_mode_one_active = 1'b0;
  logic power_save_mode_two_active = 1'b0;
  logic rx_wake_edge = 1'b0;
  logic supply_is_main = 1'b0;
  logic supply_good = 1'b1;
  logic lose_lock = 1'b0;
  logic pll_locked, pll_tick, core_tick, meter_tick, meter_off, core_shutdown, core_reset;
  logic timekeeping_unlock, external_reference_enable, rx_serial_select, rx_wake_enable, irq;
  logic [7:0] rd_data;
  logic [2:0] core_clock_divider;
  int n_errors = 0;
  int comparisons = 0;
  int cycles = 0;

  always #5 clk = ~clk;

  pccp_xtal_model xtal (.clk(clk), .arst_n(arst_n), .lose_lock(lose_lock),
    .pll_locked(pll_locked));

  pccp_top dut (.clk(clk), .arst_n(arst_n), .addr(addr), .wr_data(wr_data), .wr_en(wr_en),
    .rd_en(rd_en), .rd_data(rd_data), .pll_locked(pll_locked), .power_save_mode_one_active(power_save_mode_one_active),
    .power_save_mode_two_active(power_save_mode_two_active), .rx_wake_edge(rx_wake_edge), .supply_is_main(supply_is_main),
    .supply_good(supply_good), .pll_tick(pll_tick), .core_tick(core_tick),
    .meter_tick(meter_tick), .core_clock_divider(core_clock_divider), .meter_off(meter_off),
    .core_shutdown(core_shutdown), .core_reset(core_reset),
    .timekeeping_unlock(timekeeping_unlock),
    .external_reference_enable(external_reference_enable),
    .rx_serial_select(rx_serial_select), .rx_wake_enable(rx_wake_enable), .irq(irq));

  task automatic final_report();
    if (n_errors == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // the full divider sweep needs about 50k cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 90000) begin
      n_errors++;
      final_report();
    end
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  function automatic logic [7:0] near(input int seen, input int exp, input int tol);
    return 8'(seen >= exp - tol && seen <= exp + tol);
  endfunction

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wr_data <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask

  task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1;
    check(rd_data, exp);
  endtask

  // counts ticks over 256 pll ticks; core ticks lag by a cycle, hence the tolerance
  task automatic measure(input int d);
    int np;
    int nc;
    int nm;
    int ncyc;
    int gap;
    logic bad;
    np = 0;
    nc = 0;
    nm = 0;
    ncyc = 0;
    gap = 0;
    bad = 1'b0;
    while (np < 256) begin
      @(posedge clk);
      #1;
      ncyc++;
      gap++;
      if (pll_tick === 1'b1) begin
        if (np > 0 && (gap < 24 || gap > 25)) bad = 1'b1;
        np++;
        gap = 0;
      end
      if (core_tick === 1'b1) nc++;
      if (meter_tick === 1'b1) nm++;
    end
    check(8'(bad), 8'h00);
    check(near(ncyc, 6250, 25), 8'h01);
    check(near(nc, 256 >> d, 1), 8'h01);
    check(near(nm, 51, 1), 8'h01);
  endtask

  initial begin
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    tick(20);
    check(8'(core_clock_divider), 8'h02);
    rdc(8'hc5, 8'h02);
    rdc(8'hf4, 8'h20);
    @(posedge clk);
    supply_is_main <= 1'b1;
    supply_good <= 1'b0;
    rdc(8'hf4, 8'h40);
    wr(8'hc5, 8'h55);
    rdc(8'hc5, 8'h02);
    wr(8'hc1, 8'ha7);
    rdc(8'hf4, 8'h40);
    wr(8'hc5, 8'hff);
    rdc(8'hc5, 8'h57);
    check(8'({meter_off, core_shutdown}), 8'h02);
    @(posedge clk);
    power_save_mode_one_active <= 1'b1;
    tick(1);
    check(8'(core_shutdown), 8'h01);
    wr(8'hc5, 8'h00);
    rdc(8'hc5, 8'h57);
    wr(8'hc1, 8'ha7);
    wr(8'hf4, 8'h00);
    wr(8'hc5, 8'h00);
    rdc(8'hc5, 8'h57);
    wr(8'hc1, 8'hea);
    tick(1);
    check(8'(timekeeping_unlock), 8'h01);
    wr(8'hc5, 8'h00);
    rdc(8'hc5, 8'h57);
    check(8'(timekeeping_unlock), 8'h00);
    for (int d = 0; d < 8; d++) begin
      wr(8'hc1, 8'ha7);
      wr(8'hc5, 8'(d));
      tick(1);
      check(8'(core_clock_divider), 8'(d));
      measure(d);
    end
    wr(8'he1, 8'h01);
    @(posedge clk);
    lose_lock <= 1'b1;
    @(posedge clk);
    lose_lock <= 1'b0;
    tick(1);
    check(8'({core_reset, irq}), 8'h03);
    tick(1);
    check(8'(core_reset), 8'h00);
    rdc(8'hf4, 8'h50);
    rdc(8'he0, 8'h01);
    tick(20);
    wr(8'hd8, 8'h80);
    rdc(8'hf4, 8'h40);
    rdc(8'hd8, 8'h00);
    wr(8'he0, 8'h01);
    tick(2);
    check(8'(irq), 8'h00);
    for (int f = 0; f < 4; f++) begin
      wr(8'hf4, 8'(f));
      tick(1);
      check(8'({rx_serial_select, rx_wake_enable}), 8'(f == 1 ? 2 : f == 3 ? 3 : 0));
    end
    @(posedge clk);
    rx_wake_edge <= 1'b1;
    @(posedge clk);
    rx_wake_edge <= 1'b0;
    rdc(8'hf4, 8'h43);
    @(posedge clk);
    power_save_mode_two_active <= 1'b1;
    rx_wake_edge <= 1'b1;
    @(posedge clk);
    rx_wake_edge <= 1'b0;
    power_save_mode_two_active <= 1'b0;
    rdc(8'hf4, 8'hc3);
    rdc(8'he0, 8'h02);
    check(8'(irq), 8'h00);
    wr(8'he1, 8'h03);
    tick(2);
    check(8'(irq), 8'h01);
    wr(8'hf4, 8'h83);
    wr(8'he0, 8'h02);
    rdc(8'hf4, 8'h43);
    check(8'(irq), 8'h00);
    wr(8'hf4, 8'h0c);
    rdc(8'hf4, 8'h44);
    check(8'(external_reference_enable), 8'h01);
    wr(8'h10, 8'hff);
    rdc(8'h10, 8'h00);
    rdc(8'hc1, 8'h00);
    final_report();
  end
endmodule
